// >>> logic/tfcpa_pkg.sv
// tfcpa_pkg: register map, field positions, encodings and carriers for the
// timer flag, channel value and pulse accumulator block.
// assumes one bus clock and a plain register port addressed by word index.
package tfcpa_pkg;

  localparam int NUM_CH = 4;

  // register indices on the plain port
  localparam logic [3:0] ADDR_SYS_ONE = 4'h0;
  localparam logic [3:0] ADDR_SYS_TWO = 4'h1;
  localparam logic [3:0] ADDR_CH_MODE = 4'h2;
  localparam logic [3:0] ADDR_CAP_EDGE = 4'h3;
  localparam logic [3:0] ADDR_COUNTER = 4'h4;
  localparam logic [3:0] ADDR_FLAGS_TWO = 4'h5;
  localparam logic [3:0] ADDR_ACC_CTRL = 4'h6;
  localparam logic [3:0] ADDR_ACC_FLAG = 4'h7;
  localparam logic [3:0] ADDR_CH_VALUE = 4'h8;
  localparam logic [3:0] ADDR_ACC_COUNT = 4'hc;

  // field positions
  localparam int SYS_ONE_TIMER_EN = 7;
  localparam int SYS_ONE_FAST_CLR = 4;
  localparam int SYS_TWO_OVF_IRQ_EN = 7;
  localparam int SYS_TWO_RST_CH3 = 3;
  localparam int SYS_TWO_PRE_LSB = 0;
  localparam int FLAGS_OVF = 7;
  localparam int ACC_ENABLE = 6;
  localparam int ACC_MODE = 5;
  localparam int ACC_EDGE = 4;
  localparam int ACC_CLK_LSB = 2;
  localparam int ACC_FLAG_INPUT = 0;

  // writable bits; the rest read as zero
  localparam logic [7:0] SYS_ONE_MASK = 8'h90;
  localparam logic [7:0] SYS_TWO_MASK = 8'h8f;
  localparam logic [7:0] FLAGS_TWO_MASK = 8'h8f;
  localparam logic [7:0] ACC_CTRL_MASK = 8'h7c;

  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [7:0] ACC_BYTE_MAX = 8'hff;
  localparam logic [5:0] DIV64_LAST = 6'h3f;
  localparam logic [6:0] PRE_ALL_ONES = 7'h7f;

  typedef enum logic [1:0] {
    CLK_PRESCALER = 2'b00,
    CLK_ACCUM = 2'b01,
    CLK_ACCUM_256 = 2'b10,
    CLK_ACCUM_65536 = 2'b11
  } tfcpa_clk_sel_type;

  typedef enum logic [1:0] {
    CAP_OFF = 2'b00,
    CAP_RISE = 2'b01,
    CAP_FALL = 2'b10,
    CAP_ANY = 2'b11
  } tfcpa_cap_edge_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [15:0] wdata;
  } tfcpa_bus_type;

  typedef struct packed {
    logic [3:0] ch_s1;
    logic [3:0] ch_s2;
    logic [3:0] ch_s3;
    logic acc_s1;
    logic acc_s2;
    logic acc_s3;
    logic [7:0] sys_one;
    logic [7:0] sys_two;
    logic [3:0] ch_mode;
    logic [7:0] cap_edge;
    logic [15:0] counter;
    logic [6:0] prescale;
    logic [7:0] flags_two;
    logic [7:0] acc_ctrl;
    logic acc_flag;
    logic [15:0] acc_count;
    logic [3:0][15:0] ch_value;
    logic [15:0] rd_data;
    logic irq;
    logic [3:0] match;
  } tfcpa_state_type;

  localparam tfcpa_state_type STATE_RESET = '0;

endpackage : tfcpa_pkg

// >>> logic/tfcpa_top.sv
// tfcpa_top: overflow and channel flags, channel capture/compare values,
// pulse accumulator and counter clock selection of a 4-channel timer.
// assumes the bus master keeps strobes one cycle long and never both at
// once; pins arrive asynchronously and are synchronised here.
//
// How it works
// - counter wrap to zero sets overflow flag
// - interrupt while overflow flag and enable set
// - overflow flag: write one clears, zero keeps
// - no overflow flag when channel3 all-ones reset
// - set overflow flag never blocks later overflows
// - capture or compare event sets channel flag
// - channel flag: write one clears, zero keeps
// - fast clear: counter access clears flag register
// - capture copies counter into channel value
// - compare channel holds software written value
// - writes to capture channel value are ignored
// - accumulator enable bit six
// - event counting ignores timer enable
// - bit five picks gated or event mode
// - edge select picks counted input edge
// - gated: level gates div64, trailing edge flags
// - div64 clock from prescaler, only when running
// - clock select: prescaler, accum, /256, /65536
// - clock select change acts at once
// - accumulator off forces prescaler counter clock
// - overflow interrupt enable bit seven
// - counter reset on channel3 compare match
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module tfcpa_top (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire tfcpa_pkg::tfcpa_bus_type I_BUS,
  input wire logic [3:0] I_CH_PIN,
  input wire logic I_ACCUM_PIN,
  output logic [15:0] O_RD_DATA,
  output logic O_IRQ,
  output logic [3:0] O_CH_MATCH
);
  import tfcpa_pkg::*;

  tfcpa_state_type q;
  tfcpa_state_type d;

  logic timer_en;
  logic fast_clr_en;
  logic rst_on_ch3;
  logic acc_en;
  logic acc_gated;
  logic acc_edge;
  tfcpa_clk_sel_type clk_sel;
  logic [7:0] pre_span;
  logic [6:0] pre_mask;
  logic pre_tick;
  logic div64_tick;
  logic acc_rise;
  logic acc_fall;
  logic acc_sel_edge;
  logic gate_open;
  logic acc_tick;
  logic acc_tick_256;
  logic acc_tick_65536;
  logic cnt_src;
  logic cnt_tick;
  logic ch3_reset;
  logic ovf_suppress;
  logic ovf_event;
  logic [15:0] cnt_next;
  logic [3:0] ch_rise;
  logic [3:0] ch_fall;
  logic [3:0] cap_event;
  logic [3:0] cmp_event;
  logic [3:0] ch_event;
  logic cnt_access;
  logic fast_clr;
  logic ch_page;
  logic [1:0] ch_idx;

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d = q;
    d.match = 4'h0;
    d.rd_data = 16'h0000;

    // pins pass three flops; only the second and later stages are read
    d.ch_s1 = I_CH_PIN;
    d.ch_s2 = q.ch_s1;
    d.ch_s3 = q.ch_s2;
    d.acc_s1 = I_ACCUM_PIN;
    d.acc_s2 = q.acc_s1;
    d.acc_s3 = q.acc_s2;

    timer_en = q.sys_one[SYS_ONE_TIMER_EN];
    fast_clr_en = q.sys_one[SYS_ONE_FAST_CLR];
    rst_on_ch3 = q.sys_two[SYS_TWO_RST_CH3];
    acc_en = q.acc_ctrl[ACC_ENABLE];
    acc_gated = q.acc_ctrl[ACC_MODE];
    acc_edge = q.acc_ctrl[ACC_EDGE];
    clk_sel = tfcpa_clk_sel_type'(q.acc_ctrl[ACC_CLK_LSB +: 2]);

    // prescaler: divisor is two to the power of the select field
    pre_span = 8'h01 << q.sys_two[SYS_TWO_PRE_LSB +: 3];
    pre_mask = 7'(pre_span - 8'h01);
    pre_tick = timer_en && ((q.prescale | ~pre_mask) == PRE_ALL_ONES);
    div64_tick = timer_en && (q.prescale[5:0] == DIV64_LAST);
    d.prescale = timer_en ? 7'(q.prescale + 7'h01) : 7'h00;

    // accumulator clock, built from the synchronised input and, in gated mode, the div64 tick
    acc_rise = q.acc_s2 && !q.acc_s3;
    acc_fall = !q.acc_s2 && q.acc_s3;
    acc_sel_edge = acc_edge ? acc_rise : acc_fall;
    gate_open = acc_edge ? !q.acc_s2 : q.acc_s2;
    // event mode does not look at the timer enable at all
    if (acc_gated) begin
      acc_tick = acc_en && gate_open && div64_tick;
    end else begin
      acc_tick = acc_en && acc_sel_edge;
    end
    acc_tick_256 = acc_tick && (q.acc_count[7:0] == ACC_BYTE_MAX);
    acc_tick_65536 = acc_tick && (q.acc_count == COUNT_MAX);
    if (acc_tick) begin
      d.acc_count = q.acc_count + 16'h0001;
    end

    // counter clock source, taken straight from the live select bits
    unique case (clk_sel)
      CLK_PRESCALER: cnt_src = pre_tick;
      CLK_ACCUM: cnt_src = acc_tick;
      CLK_ACCUM_256: cnt_src = acc_tick_256;
      CLK_ACCUM_65536: cnt_src = acc_tick_65536;
    endcase
    if (!acc_en) begin
      cnt_src = pre_tick;
    end
    cnt_tick = timer_en && cnt_src;

    // free-running counter
    ch3_reset = rst_on_ch3 && q.ch_mode[3] && (q.counter == q.ch_value[3]);
    cnt_next = ch3_reset ? 16'h0000 : q.counter + 16'h0001;
    ovf_suppress = rst_on_ch3 && (q.ch_value[3] == COUNT_MAX);
    ovf_event = cnt_tick && (q.counter == COUNT_MAX) && !ovf_suppress;
    if (cnt_tick) begin
      d.counter = cnt_next;
    end

    // channel events
    ch_rise = q.ch_s2 & ~q.ch_s3;
    ch_fall = ~q.ch_s2 & q.ch_s3;
    for (int i = 0; i < NUM_CH; i++) begin
      unique case (tfcpa_cap_edge_type'(q.cap_edge[2 * i +: 2]))
        CAP_OFF: cap_event[i] = 1'b0;
        CAP_RISE: cap_event[i] = ch_rise[i];
        CAP_FALL: cap_event[i] = ch_fall[i];
        CAP_ANY: cap_event[i] = ch_rise[i] || ch_fall[i];
      endcase
      cap_event[i] = cap_event[i] && !q.ch_mode[i];
      cmp_event[i] = q.ch_mode[i] && cnt_tick && (cnt_next == q.ch_value[i]);
    end
    ch_event = cap_event | cmp_event;
    d.match = cmp_event;

    // register writes come first so that hardware sets below win
    cnt_access = (I_BUS.wr || I_BUS.rd) && (I_BUS.addr == ADDR_COUNTER);
    fast_clr = fast_clr_en && cnt_access;
    ch_page = I_BUS.addr[3:2] == ADDR_CH_VALUE[3:2];
    ch_idx = I_BUS.addr[1:0];
    if (fast_clr) begin
      d.flags_two = 8'h00;
    end
    if (I_BUS.wr) begin
      unique case (I_BUS.addr)
        ADDR_SYS_ONE: d.sys_one = I_BUS.wdata[7:0] & SYS_ONE_MASK;
        ADDR_SYS_TWO: d.sys_two = I_BUS.wdata[7:0] & SYS_TWO_MASK;
        ADDR_CH_MODE: d.ch_mode = I_BUS.wdata[3:0];
        ADDR_CAP_EDGE: d.cap_edge = I_BUS.wdata[7:0];
        ADDR_FLAGS_TWO: begin
          // one clears, zero leaves the bit alone
          d.flags_two = d.flags_two & ~(I_BUS.wdata[7:0] & FLAGS_TWO_MASK);
        end
        ADDR_ACC_CTRL: d.acc_ctrl = I_BUS.wdata[7:0] & ACC_CTRL_MASK;
        ADDR_ACC_FLAG: begin
          if (I_BUS.wdata[ACC_FLAG_INPUT]) begin
            d.acc_flag = 1'b0;
          end
        end
        ADDR_ACC_COUNT: d.acc_count = I_BUS.wdata;
        default: begin
          if (ch_page && q.ch_mode[ch_idx]) begin
            d.ch_value[ch_idx] = I_BUS.wdata;
          end
        end
      endcase
    end

    // hardware sets; an already set flag never masks a new event
    if (ovf_event) begin
      d.flags_two[FLAGS_OVF] = 1'b1;
    end
    d.flags_two[3:0] = d.flags_two[3:0] | ch_event;
    for (int i = 0; i < NUM_CH; i++) begin
      if (cap_event[i]) begin
        d.ch_value[i] = q.counter;
      end
    end
    // the counted edge doubles as the trailing edge of the gate
    if (acc_en && acc_sel_edge) begin
      d.acc_flag = 1'b1;
    end

    d.irq = d.flags_two[FLAGS_OVF] && d.sys_two[SYS_TWO_OVF_IRQ_EN];

    // read data stands only in the cycle after the strobe
    if (I_BUS.rd) begin
      unique case (I_BUS.addr)
        ADDR_SYS_ONE: d.rd_data = {8'h00, q.sys_one};
        ADDR_SYS_TWO: d.rd_data = {8'h00, q.sys_two};
        ADDR_CH_MODE: d.rd_data = {12'h000, q.ch_mode};
        ADDR_CAP_EDGE: d.rd_data = {8'h00, q.cap_edge};
        ADDR_COUNTER: d.rd_data = q.counter;
        ADDR_FLAGS_TWO: d.rd_data = {8'h00, q.flags_two};
        ADDR_ACC_CTRL: d.rd_data = {8'h00, q.acc_ctrl};
        ADDR_ACC_FLAG: d.rd_data = {15'h0000, q.acc_flag};
        ADDR_ACC_COUNT: d.rd_data = q.acc_count;
        default: begin
          if (ch_page) begin
            d.rd_data = q.ch_value[ch_idx];
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      q <= STATE_RESET;
    end else begin
      q <= d;
    end
  end

  assign O_RD_DATA = q.rd_data;
  assign O_IRQ = q.irq;
  assign O_CH_MATCH = q.match;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);

  logic wr_flags;
  logic wr_acc_count;
  assign wr_flags = I_BUS.wr && (I_BUS.addr == ADDR_FLAGS_TWO);
  assign wr_acc_count = I_BUS.wr && (I_BUS.addr == ADDR_ACC_COUNT);

  sequence s_wrap;
    cnt_tick && (q.counter == COUNT_MAX);
  endsequence

  sequence s_trailing_edge;
    acc_en && acc_gated && acc_sel_edge;
  endsequence

  property p_ovf_set;
    s_wrap ##0 !ovf_suppress |=> q.flags_two[FLAGS_OVF];
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag missed");

  property p_irq_level;
    O_IRQ == (q.flags_two[FLAGS_OVF] && q.sys_two[SYS_TWO_OVF_IRQ_EN]);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

  property p_ovf_w1c;
    wr_flags && I_BUS.wdata[FLAGS_OVF] && !ovf_event |=> !q.flags_two[FLAGS_OVF];
  endproperty
  a_ovf_w1c: assert property (p_ovf_w1c) else $error("overflow flag not cleared");

  property p_ovf_keep;
    q.flags_two[FLAGS_OVF] && !fast_clr && !(wr_flags && I_BUS.wdata[FLAGS_OVF])
      |=> q.flags_two[FLAGS_OVF];
  endproperty
  a_ovf_keep: assert property (p_ovf_keep) else $error("overflow flag lost");

  property p_ovf_suppress;
    s_wrap ##0 (ovf_suppress && !q.flags_two[FLAGS_OVF]) |=> !q.flags_two[FLAGS_OVF];
  endproperty
  a_ovf_suppress: assert property (p_ovf_suppress) else $error("overflow flag set");

  property p_ch_w1c;
    wr_flags && !(|ch_event) |=> (q.flags_two[3:0] & $past(I_BUS.wdata[3:0])) == 4'h0;
  endproperty
  a_ch_w1c: assert property (p_ch_w1c) else $error("channel flag not cleared");

  property p_ch_set;
    (|ch_event) |=> ((q.flags_two[3:0] & $past(ch_event)) == $past(ch_event));
  endproperty
  a_ch_set: assert property (p_ch_set) else $error("channel flag missed");

  property p_fast_clr;
    fast_clr && !ovf_event && !(|ch_event) |=> q.flags_two == 8'h00;
  endproperty
  a_fast_clr: assert property (p_fast_clr) else $error("fast clear failed");

  property p_capture;
    cap_event[0] |=> q.ch_value[0] == $past(q.counter);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_cap_wr_ignored;
    I_BUS.wr && ch_page && !q.ch_mode[ch_idx] && !cap_event[ch_idx]
      |=> q.ch_value[$past(ch_idx)] == $past(q.ch_value[ch_idx]);
  endproperty
  a_cap_wr_ignored: assert property (p_cap_wr_ignored) else $error("capture value written");

  property p_event_count;
    acc_en && !acc_gated && acc_sel_edge && !wr_acc_count
      |=> q.acc_count == $past(q.acc_count) + 16'h0001;
  endproperty
  a_event_count: assert property (p_event_count) else $error("event not counted");

  property p_trailing_flag;
    s_trailing_edge |=> q.acc_flag;
  endproperty
  a_trailing_flag: assert property (p_trailing_flag) else $error("gate edge flag missed");

  property p_gated_idle;
    acc_en && acc_gated && !timer_en && !wr_acc_count |=> $stable(q.acc_count);
  endproperty
  a_gated_idle: assert property (p_gated_idle) else $error("gated count without timer");

  property p_acc_off_clock;
    !acc_en && timer_en && pre_tick && !ch3_reset
      |=> q.counter == $past(q.counter) + 16'h0001;
  endproperty
  a_acc_off_clock: assert property (p_acc_off_clock) else $error("counter clock wrong");

  property p_ch3_reset;
    cnt_tick && ch3_reset |=> q.counter == 16'h0000;
  endproperty
  a_ch3_reset: assert property (p_ch3_reset) else $error("channel 3 reset missed");

  // a flag already pending must not swallow the next wrap
  property p_ovf_again;
    s_wrap ##0 (q.flags_two[FLAGS_OVF] && !ovf_suppress) |=> q.flags_two[FLAGS_OVF];
  endproperty
  a_ovf_again: assert property (p_ovf_again) else $error("pending overflow blocked");

  property p_match_flag;
    (|O_CH_MATCH) |-> ((q.flags_two[3:0] & O_CH_MATCH) == O_CH_MATCH);
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match without flag");

  property p_cmp_write;
    I_BUS.wr && ch_page && q.ch_mode[ch_idx]
      |=> q.ch_value[$past(ch_idx)] == $past(I_BUS.wdata);
  endproperty
  a_cmp_write: assert property (p_cmp_write) else $error("compare value not written");

  property p_acc_off_hold;
    !acc_en && !wr_acc_count |=> $stable(q.acc_count);
  endproperty
  a_acc_off_hold: assert property (p_acc_off_hold) else $error("idle count moved");

  property p_gated_count;
    acc_en && acc_gated && gate_open && div64_tick && !wr_acc_count
      |=> q.acc_count == $past(q.acc_count) + 16'h0001;
  endproperty
  a_gated_count: assert property (p_gated_count) else $error("gated tick lost");

  property p_sel_accum;
    acc_en && (clk_sel == CLK_ACCUM) && timer_en && acc_tick && !ch3_reset
      |=> q.counter == $past(q.counter) + 16'h0001;
  endproperty
  a_sel_accum: assert property (p_sel_accum) else $error("accum clock missed");

  // an edge is only seen once the pin has crossed both sync stages
  property p_acc_sync;
    acc_rise |-> $past(I_ACCUM_PIN, 2);
  endproperty
  a_acc_sync: assert property (p_acc_sync) else $error("edge ahead of sync");

endmodule : tfcpa_top

`default_nettype wire

// >>> verif/tfcpa_bench.sv
// tfcpa_bench: self-checking bench for the timer flag and accumulator block.
// assumes the plain register port and the pin model beside the design.
`timescale 1ns/1ps
`default_nettype none

module tfcpa_bench;
  import tfcpa_pkg::*;
  logic I_CLK, I_RST_N;
  tfcpa_bus_type bus;
  logic [3:0] ch;
  logic acc;
  logic [15:0] O_RD_DATA;
  logic O_IRQ;
  logic [3:0] O_CH_MATCH;
  logic [15:0] v, c;
  logic [31:0] seed;
  logic hit;
  logic [3:0] m;
  int fails, checked, cycles;

  tfcpa_top dut_u (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_BUS(bus), .I_CH_PIN(ch),
    .I_ACCUM_PIN(acc), .O_RD_DATA(O_RD_DATA), .O_IRQ(O_IRQ), .O_CH_MATCH(O_CH_MATCH));
  tfcpa_pin_model pins_u (.i_clk(I_CLK), .o_ch(ch), .o_acc(acc));

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  function automatic logic [15:0] preset(input int sel);
    return (sel == 3) ? 16'hfffe : (sel == 2) ? 16'h00fe : 16'h0000;
  endfunction : preset
  function automatic logic [15:0] delta(input int sel);
    return (sel == 1) ? 16'h0002 : 16'h0001;
  endfunction : delta
  // a full pulse gives both edges, so any mode but off flags the channel
  function automatic logic [15:0] cap_exp(input logic [7:0] e, input int i);
    return (e[2 * i +: 2] == 2'b00) ? 16'h0000 : (16'h0001 << i);
  endfunction : cap_exp

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge I_CLK);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge I_CLK);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge I_CLK);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge I_CLK);
    bus.rd <= 1'b0;
    @(negedge I_CLK);
    d = O_RD_DATA;
  endtask : rd
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic ok(input string n, input logic b);
    chk(n, {15'h0000, b}, 16'h0001);
  endtask : ok
  task automatic rc(input logic [3:0] a, input logic [15:0] e, input string n);
    rd(a, v);
    chk(n, v, e);
  endtask : rc
  task automatic pulse_acc();
    pins_u.set_acc(1'b1);
    pins_u.set_acc(1'b0);
  endtask : pulse_acc
  task automatic final_report();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    I_CLK = 1'b0;
    forever #25 I_CLK = ~I_CLK;
  end
  // whole run is about 70k clocks, dominated by one full counter wrap
  always @(posedge I_CLK) begin
    cycles++;
    if (cycles == 90000) begin
      fails++;
      final_report();
    end
  end

  initial begin
    bus = '0;
    I_RST_N = 1'b0;
    seed = 32'h933f;
    repeat (12) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    for (int a = 0; a < 14; a++) rc(a[3:0], 16'h0000, "reset");
    wr(4'hd, 16'hffff);
    rc(4'hd, 16'h0000, "unmapped");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr(ADDR_SYS_TWO, seed[15:0]);
      rc(ADDR_SYS_TWO, seed[15:0] & {8'h00, SYS_TWO_MASK}, "sys_two");
      wr(ADDR_ACC_CTRL, seed[31:16]);
      rc(ADDR_ACC_CTRL, seed[31:16] & {8'h00, ACC_CTRL_MASK}, "acc_ctrl");
    end
    wr(ADDR_SYS_TWO, 16'h0000);
    wr(ADDR_CH_MODE, 16'h000e);
    for (int i = 1; i < 4; i++) begin
      seed = xs(seed);
      wr(ADDR_CH_VALUE + i[3:0], seed[15:0]);
      rc(ADDR_CH_VALUE + i[3:0], seed[15:0], "cmp_value");
    end
    wr(ADDR_CH_VALUE, 16'h1234);
    rc(ADDR_CH_VALUE, 16'h0000, "cap_write");
    // event counting with the timer stopped; single levels pick the edge
    wr(ADDR_ACC_CTRL, 16'h0050);
    pins_u.set_acc(1'b1);
    rc(ADDR_ACC_COUNT, 16'h0001, "rise_cnt");
    pins_u.set_acc(1'b0);
    rc(ADDR_ACC_COUNT, 16'h0001, "rise_only");
    rc(ADDR_ACC_FLAG, 16'h0001, "acc_flag");
    wr(ADDR_ACC_CTRL, 16'h0040);
    pins_u.set_acc(1'b1);
    rc(ADDR_ACC_COUNT, 16'h0001, "fall_only");
    pins_u.set_acc(1'b0);
    rc(ADDR_ACC_COUNT, 16'h0002, "fall_cnt");
    seed = xs(seed);
    for (int i = 0; i <= seed[1:0]; i++) pulse_acc();
    rc(ADDR_ACC_COUNT, 16'h0003 + seed[1:0], "rand_cnt");
    wr(ADDR_ACC_CTRL, 16'h0010);
    pulse_acc();
    rc(ADDR_ACC_COUNT, 16'h0003 + seed[1:0], "acc_off");
    // gated: pin already low, registers set before the timer starts
    wr(ADDR_ACC_COUNT, 16'h0000);
    wr(ADDR_ACC_FLAG, 16'h0001);
    wr(ADDR_ACC_CTRL, 16'h0070);
    wr(ADDR_SYS_ONE, 16'h0080);
    repeat (640) @(posedge I_CLK);
    pins_u.set_acc(1'b1);
    rd(ADDR_ACC_COUNT, c);
    ok("gated_cnt", c >= 16'd9 && c <= 16'd11);
    rc(ADDR_ACC_FLAG, 16'h0001, "trail_flag");
    wr(ADDR_SYS_ONE, 16'h0000);
    pins_u.set_acc(1'b0);
    repeat (640) @(posedge I_CLK);
    rc(ADDR_ACC_COUNT, c, "no_div64");
    // capture on channel 0 rising edge
    wr(ADDR_ACC_CTRL, 16'h0000);
    wr(ADDR_SYS_ONE, 16'h0080);
    wr(ADDR_CAP_EDGE, 16'h0001);
    wr(ADDR_FLAGS_TWO, 16'h008f);
    pins_u.pulse_ch(0);
    rd(ADDR_CH_VALUE, v);
    rd(ADDR_COUNTER, c);
    ok("capture", c > v && c - v < 16'd40);
    rc(ADDR_FLAGS_TWO, 16'h0001, "ch_flag");
    wr(ADDR_FLAGS_TWO, 16'h0000);
    rc(ADDR_FLAGS_TWO, 16'h0001, "w0_keep");
    wr(ADDR_FLAGS_TWO, 16'h0001);
    rc(ADDR_FLAGS_TWO, 16'h0000, "w1_clear");
    wr(ADDR_SYS_ONE, 16'h0090);
    pins_u.pulse_ch(0);
    rc(ADDR_FLAGS_TWO, 16'h0001, "ch_flag2");
    rd(ADDR_COUNTER, c);
    rc(ADDR_FLAGS_TWO, 16'h0000, "fast_clr");
    // every channel as capture, edge modes drawn at random
    wr(ADDR_CH_MODE, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr(ADDR_CAP_EDGE, {8'h00, seed[7:0]});
      wr(ADDR_FLAGS_TWO, 16'h000f);
      pins_u.pulse_ch(i);
      rd(ADDR_FLAGS_TWO, v);
      chk("cap_flag", v & 16'h000f, cap_exp(seed[7:0], i));
    end
    // all channels compare; channel 3 compare resets the counter
    wr(ADDR_SYS_ONE, 16'h0080);
    wr(ADDR_CH_MODE, 16'h000f);
    rd(ADDR_COUNTER, c);
    for (int i = 0; i < 3; i++) wr(ADDR_CH_VALUE + i[3:0], c + 16'h0020 + 16'(i));
    wr(ADDR_CH_VALUE + 4'h3, c + 16'h0040);
    wr(ADDR_SYS_TWO, 16'h0008);
    hit = 1'b0;
    m = 4'h0;
    for (int k = 0; k < 200 && hit !== 1'b1; k++) begin
      @(negedge I_CLK);
      hit = O_CH_MATCH[3];
      m = m | O_CH_MATCH;
    end
    ok("match3", hit);
    chk("match_all", {12'h000, m}, 16'h000f);
    rd(ADDR_COUNTER, c);
    ok("ch3_reset", c < 16'h0010);
    rd(ADDR_FLAGS_TWO, v);
    ok("ch3_flag", v[3]);
    wr(ADDR_SYS_TWO, 16'h0000);
    for (int sel = 1; sel < 4; sel++) begin
      wr(ADDR_ACC_COUNT, preset(sel));
      wr(ADDR_ACC_CTRL, 16'h0050 | 16'(sel << 2));
      rd(ADDR_COUNTER, c);
      rc(ADDR_COUNTER, c, "sel_now");
      pulse_acc();
      pulse_acc();
      rc(ADDR_COUNTER, c + delta(sel), "sel_step");
    end
    wr(ADDR_ACC_CTRL, 16'h0004);
    rd(ADDR_COUNTER, c);
    repeat (20) @(posedge I_CLK);
    rd(ADDR_COUNTER, v);
    ok("acc_off_pre", v > c);
    // one full wrap with the prescaler at divide by one
    wr(ADDR_FLAGS_TWO, 16'h008f);
    v = 16'h0000;
    for (int k = 0; k < 40000 && v[7] !== 1'b1; k++) rd(ADDR_FLAGS_TWO, v);
    ok("ovf_set", v[7]);
    rd(ADDR_COUNTER, c);
    ok("wrap_zero", c < 16'h0020);
    chk("irq_masked", {15'h0000, O_IRQ}, 16'h0000);
    wr(ADDR_SYS_TWO, 16'h0080);
    repeat (2) @(posedge I_CLK);
    @(negedge I_CLK);
    chk("irq_on", {15'h0000, O_IRQ}, 16'h0001);
    wr(ADDR_FLAGS_TWO, 16'h0000);
    rd(ADDR_FLAGS_TWO, v);
    ok("ovf_w0", v[7]);
    wr(ADDR_FLAGS_TWO, 16'h0080);
    rd(ADDR_FLAGS_TWO, v);
    ok("ovf_w1", !v[7]);
    chk("irq_off", {15'h0000, O_IRQ}, 16'h0000);
    final_report();
  end
endmodule : tfcpa_bench

`default_nettype wire

// >>> verif/tfcpa_pin_model.sv
// tfcpa_pin_model: drives the channel capture pins and the accumulator pin.
// assumes the bench calls its tasks and that the pins idle low.
`timescale 1ns/1ps
`default_nettype none

module tfcpa_pin_model (
  input wire logic i_clk,
  output logic [3:0] o_ch,
  output logic o_acc
);
  initial begin
    o_ch = 4'h0;
    o_acc = 1'b0;
  end
  // each level stands 4 clocks so the two-flop sync cannot drop it
  task automatic hold();
    repeat (4) @(posedge i_clk);
  endtask : hold
  task automatic set_acc(input logic lvl);
    @(posedge i_clk);
    o_acc <= lvl;
    hold();
  endtask : set_acc
  task automatic pulse_ch(input int idx);
    @(posedge i_clk);
    o_ch[idx] <= 1'b1;
    hold();
    o_ch[idx] <= 1'b0;
    hold();
  endtask : pulse_ch
endmodule : tfcpa_pin_model

`default_nettype wire
